// ===== rtl/irq_seq_map.vh
`ifndef IRQ_SEQ_MAP_VH
`define IRQ_SEQ_MAP_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_STATUS     4'h0
`define ADDR_ENABLE     4'h1
`define ADDR_FLAGS      4'h2
`define ADDR_CONTROL    4'h3
`define ADDR_SP_LO      4'h4
`define ADDR_SP_HI      4'h5
`define ADDR_VECTOR     4'h6
`define ADDR_STATE      4'h7
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define GIE_BIT         7
`define CTRL_RELOC_BIT  0
`define STATUS_RESET    8'h00
`define SP_RESET        16'h085f
// ----------------------------------------
// Timing counts in core clock cycles and the stack pointer step
// ----------------------------------------
`define ENTRY_CYCLES    3'h4
`define WAKE_EXTRA      3'h4
`define RETURN_CYCLES   3'h4
`define SP_STEP         16'h0002
`endif

// ===== rtl/cpu_interrupt_sequencer.v
// Behaviour
// - Core runs on undivided chip clock
// - Reset and each source own vectors
// - Take only with source and global enable
// - Lowest vector wins, reset first; a take in the reset_fetch cycle loads the interrupt vector instead
// - Relocate select moves vectors to boot
// - Boot reset fuse moves reset vector
// - Boot lock bits may block by counter
// - Accepting interrupt clears global enable
// - Return sets global enable again
// - Vectoring clears the source's flag
// - Writing one clears flag, zero keeps
// - Disabled flags stay latched until served
// - Level sources request only while present
// - One main instruction after return first
// - Status register not saved or restored
// - Clear-global blocks same-cycle requests too
// - Instruction after set-global runs first
// - Entry takes four cycles, pushes counter
// - Multi-cycle instruction completes before entry
// - Wake from sleep adds four cycles once wake_done is up
// - Return takes four cycles, pops counter
// - Push decrements stack pointer by two
// - Global enable is status bit seven
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/10ps
`include "irq_seq_map.vh"

module cpu_interrupt_sequencer #(
	parameter NSRC      = 8,
	parameter LEVEL_MSK = 8'h80,
	parameter PCW       = 14,
	parameter [PCW-1:0] BOOT_START = 14'h3800
) (
	input  wire             clk,
	input  wire             rst_n,
	input  wire [3:0]       reg_addr,
	input  wire [7:0]       reg_wdata,
	input  wire             reg_wr,
	input  wire             reg_rd,
	output reg  [7:0]       reg_rdata,
	input  wire [NSRC-1:0]  irq_event,
	input  wire [NSRC-1:0]  irq_level,
	input  wire             boot_reset_vector_fuse,
	input  wire             app_section_lock_bit,
	input  wire             boot_section_lock_bit,
	input  wire             instr_boundary,
	input  wire             instr_sei,
	input  wire             instr_cli,
	input  wire             return_from_interrupt,
	input  wire             core_sleeping,
	input  wire             wake_done,
	input  wire [PCW-1:0]   program_counter,
	input  wire             reset_fetch,
	output reg              core_stall,
	output reg              push_strobe,
	output reg              pop_strobe,
	output reg  [PCW-1:0]   vector_addr,
	output reg              vector_load,
	output reg              wake_request,
	output wire             global_irq_enable,
	output reg  [15:0]      stack_pointer
);

	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam [3:0] S_RUN   = 4'b0001;
	localparam [3:0] S_ENTRY = 4'b0010;
	localparam [3:0] S_WAKE  = 4'b0100;
	localparam [3:0] S_RET   = 4'b1000;

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	reg  [7:0]      status_flags_register_q;
	reg  [NSRC-1:0] enable_q;
	reg  [NSRC-1:0] flag_q;
	reg             vector_relocate_select_q;
	reg  [3:0]      state_q;
	reg  [2:0]      cnt_q;
	reg             hold_q;
	reg  [NSRC-1:0] win_q;
	reg  [NSRC-1:0] ev_s1_q;
	reg  [NSRC-1:0] ev_s2_q;
	reg  [NSRC-1:0] ev_s3_q;
	reg  [NSRC-1:0] lv_s1_q;
	reg  [NSRC-1:0] lv_s2_q;
	reg  [NSRC-1:0] pending;
	reg  [NSRC-1:0] win;
	reg  [PCW-1:0]  win_vec;
	reg             blocked;
	integer         i;

	reg  [NSRC-1:0] flag_clr;
	reg  [NSRC-1:0] flag_set;
	reg  [NSRC-1:0] flag_served;
	reg  [PCW-1:0]  vec_base;
	reg  [PCW-1:0]  src_offset;
	reg             take;
	reg             sp_write_lo;
	reg             sp_write_hi;

	assign global_irq_enable = status_flags_register_q[`GIE_BIT];

	// ----------------------------------------
	// Source synchronisers
	// ----------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ev_s1_q <= {NSRC{1'b0}};
			ev_s2_q <= {NSRC{1'b0}};
			ev_s3_q <= {NSRC{1'b0}};
			lv_s1_q <= {NSRC{1'b0}};
			lv_s2_q <= {NSRC{1'b0}};
		end else begin
			ev_s1_q <= irq_event;
			ev_s2_q <= ev_s1_q;
			ev_s3_q <= ev_s2_q;
			lv_s1_q <= irq_level;
			lv_s2_q <= lv_s1_q;
		end
	end

	// ----------------------------------------
	// Arbitration
	// ----------------------------------------
	// Boot lock blocks interrupts that would jump out of the protected area
	always @* begin
		blocked = 1'b0;
		if (boot_section_lock_bit && program_counter >= BOOT_START && !vector_relocate_select_q)
			blocked = 1'b1;
		if (app_section_lock_bit && program_counter < BOOT_START && vector_relocate_select_q)
			blocked = 1'b1;
		for (i = 0; i < NSRC; i = i + 1)
			pending[i] = enable_q[i] & (LEVEL_MSK[i] ? lv_s2_q[i] : flag_q[i]);
		win = {NSRC{1'b0}};
		src_offset = {PCW{1'b0}};
		win_vec = vec_base + {{(PCW-2){1'b0}}, 2'b10};
		for (i = NSRC - 1; i >= 0; i = i - 1) begin
			if (pending[i]) begin
				win = {NSRC{1'b0}};
				win[i] = 1'b1;
				src_offset = i[PCW-1:0] + {{(PCW-1){1'b0}}, 1'b1};
				win_vec = vec_base + {src_offset[PCW-2:0], 1'b0};
			end
		end
	end

	always @* begin
		take = 1'b0;
		if (state_q == S_RUN && global_irq_enable && !instr_cli && !hold_q && !blocked)
			take = (|pending) && (instr_boundary || core_sleeping);
	end

	// ----------------------------------------
	// Flag update terms
	// ----------------------------------------
	always @* begin
		// Only edge sources latch; level sources bypass the flag
		flag_set = ev_s2_q & ~ev_s3_q & ~LEVEL_MSK[NSRC-1:0];
		flag_clr = {NSRC{1'b0}};
		if (reg_wr && reg_addr == `ADDR_FLAGS)
			flag_clr = reg_wdata[NSRC-1:0];
		flag_served = {NSRC{1'b0}};
		if (take)
			flag_served = win;
		vec_base = {PCW{1'b0}};
		if (vector_relocate_select_q)
			vec_base = BOOT_START;
	end

	// ----------------------------------------
	// Interrupt flags
	// ----------------------------------------
	// latched until served
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_q <= {NSRC{1'b0}};
		end else begin
			// An edge in the clearing cycle is kept, so no request is lost
			flag_q <= (flag_q & ~flag_clr & ~flag_served) | flag_set;
		end
	end

	// ----------------------------------------
	// Stack pointer
	// ----------------------------------------
	always @* begin
		sp_write_lo = reg_wr && reg_addr == `ADDR_SP_LO;
		sp_write_hi = reg_wr && reg_addr == `ADDR_SP_HI;
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stack_pointer <= `SP_RESET;
		end else if (state_q == S_ENTRY && cnt_q == `ENTRY_CYCLES - 3'h1) begin
			stack_pointer <= stack_pointer - `SP_STEP;
		end else if (state_q == S_RET && cnt_q == `RETURN_CYCLES - 3'h1) begin
			stack_pointer <= stack_pointer + `SP_STEP;
		end else begin
			// Software writes lose to push and pop; the core is stalled then anyway
			if (sp_write_lo)
				stack_pointer[7:0] <= reg_wdata;
			if (sp_write_hi)
				stack_pointer[15:8] <= reg_wdata;
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// single undivided clock
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= S_RUN;
			cnt_q <= 3'h0;
			hold_q <= 1'b0;
			win_q <= {NSRC{1'b0}};
			status_flags_register_q <= `STATUS_RESET;
			core_stall <= 1'b0;
			push_strobe <= 1'b0;
			pop_strobe <= 1'b0;
			vector_load <= 1'b0;
			vector_addr <= {PCW{1'b0}};
			wake_request <= 1'b0;
		end else begin
			push_strobe <= 1'b0;
			pop_strobe <= 1'b0;
			vector_load <= 1'b0;
			wake_request <= 1'b0;
			if (instr_boundary)
				hold_q <= 1'b0;
			if (reg_wr && reg_addr == `ADDR_STATUS)
				status_flags_register_q <= reg_wdata;
			if (instr_cli)
				status_flags_register_q[`GIE_BIT] <= 1'b0;
			if (instr_sei) begin
				status_flags_register_q[`GIE_BIT] <= 1'b1;
				hold_q <= 1'b1;
			end
			if (reset_fetch) begin
				vector_addr <= boot_reset_vector_fuse ? BOOT_START : {PCW{1'b0}};
				vector_load <= 1'b1;
			end
			case (state_q)
			S_RUN: begin
				core_stall <= 1'b0;
				if (take) begin
					status_flags_register_q[`GIE_BIT] <= 1'b0;
					win_q <= win;
					vector_addr <= win_vec;
					core_stall <= 1'b1;
					if (core_sleeping) begin
						wake_request <= 1'b1;
						state_q <= S_WAKE;
						cnt_q <= `WAKE_EXTRA;
					end else begin
						state_q <= S_ENTRY;
						cnt_q <= `ENTRY_CYCLES - 3'h1;
					end
				end else if (return_from_interrupt) begin
					core_stall <= 1'b1;
					state_q <= S_RET;
					cnt_q <= `RETURN_CYCLES - 3'h1;
				end
			end
			S_WAKE: begin
				if (wake_done) begin
					if (cnt_q == 3'h1) begin
						state_q <= S_ENTRY;
						cnt_q <= `ENTRY_CYCLES;
					end else begin
						cnt_q <= cnt_q - 3'h1;
					end
				end
			end
			S_ENTRY: begin
				if (cnt_q == `ENTRY_CYCLES - 3'h1)
					push_strobe <= 1'b1;
				if (cnt_q == 3'h1) begin
					vector_load <= 1'b1;
					core_stall <= 1'b0;
					state_q <= S_RUN;
				end
				cnt_q <= cnt_q - 3'h1;
			end
			S_RET: begin
				if (cnt_q == `RETURN_CYCLES - 3'h1) begin
					pop_strobe <= 1'b1;
				end
				if (cnt_q == 3'h1) begin
					status_flags_register_q[`GIE_BIT] <= 1'b1;
					hold_q <= 1'b1;
					core_stall <= 1'b0;
					state_q <= S_RUN;
				end
				cnt_q <= cnt_q - 3'h1;
			end
			default: begin
				state_q <= S_RUN;
				core_stall <= 1'b0;
			end
			endcase
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			enable_q <= {NSRC{1'b0}};
			vector_relocate_select_q <= 1'b0;
		end else if (reg_wr) begin
			if (reg_addr == `ADDR_ENABLE)
				enable_q <= reg_wdata[NSRC-1:0];
			if (reg_addr == `ADDR_CONTROL)
				vector_relocate_select_q <= reg_wdata[`CTRL_RELOC_BIT];
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
			`ADDR_STATUS:  reg_rdata <= status_flags_register_q;
			`ADDR_ENABLE:  reg_rdata <= enable_q;
			`ADDR_FLAGS:   reg_rdata <= flag_q;
			`ADDR_CONTROL: reg_rdata <= {7'h00, vector_relocate_select_q};
			`ADDR_SP_LO:   reg_rdata <= stack_pointer[7:0];
			`ADDR_SP_HI:   reg_rdata <= stack_pointer[15:8];
			`ADDR_VECTOR:  reg_rdata <= vector_addr[7:0];
			`ADDR_STATE:   reg_rdata <= {hold_q, cnt_q, state_q};
			default:       reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

endmodule

// ===== verif/cpu_interrupt_sequencer_properties.sv
`timescale 1ns/10ps
`include "irq_seq_map.vh"
module irq_seq_checker (
	input wire        clk,
	input wire        rst_n,
	input wire [3:0]  reg_addr,
	input wire        reg_rd,
	input wire [7:0]  reg_rdata,
	input wire        instr_cli,
	input wire        core_stall,
	input wire        push_strobe,
	input wire        pop_strobe,
	input wire        vector_load,
	input wire        wake_request,
	input wire        global_irq_enable,
	input wire [15:0] stack_pointer
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ----------------------------------------
	// Entry and return tails
	// ----------------------------------------
	sequence s_entry_tail; ##2 vector_load; endsequence
	sequence s_return_tail; ##2 global_irq_enable; endsequence
	AST_PUSH_LOAD: assert property (push_strobe |-> s_entry_tail)
		else $error("vector load not two cycles after push");
	AST_POP_GIE: assert property (pop_strobe |-> s_return_tail)
		else $error("global enable not set after pop");
	AST_STALL_LEN: assert property ($rose(core_stall) |-> core_stall [*3])
		else $error("core hold shorter than return span");
	AST_LOAD_GIE_OFF: assert property (vector_load |-> !global_irq_enable)
		else $error("global enable still set at vector load");
	// Stall keeps register writes out, so three cycles back is the old value
	AST_SP_PUSH: assert property (push_strobe |->
		##2 (stack_pointer == $past(stack_pointer, 3) - `SP_STEP))
		else $error("stack pointer not lowered by two");
	AST_SP_POP: assert property (pop_strobe |->
		##2 (stack_pointer == $past(stack_pointer, 3) + `SP_STEP))
		else $error("stack pointer not raised by two");
	AST_CLI_BLOCK: assert property (instr_cli && !core_stall |=> !vector_load [*6])
		else $error("interrupt taken after clear-global");
	AST_GIE_READ: assert property (reg_rd && reg_addr == `ADDR_STATUS |=>
		reg_rdata[`GIE_BIT] == $past(global_irq_enable))
		else $error("status bit seven differs from global enable");
	AST_WAKE: assert property (wake_request |=> !vector_load [*7])
		else $error("vector load too early after wake");
endmodule
bind cpu_interrupt_sequencer irq_seq_checker irq_seq_checker_inst (.*);

// ===== verif/core_model.sv
`timescale 1ns/10ps
module core_model (
	input  wire        clk,
	input  wire        rst_n,
	input  wire        core_stall,
	input  wire        core_sleeping,
	input  wire        wake_request,
	output wire        instr_boundary,
	output reg         wake_done,
	output reg  [13:0] program_counter
);
	// one instruction per clock, none while held or asleep
	assign instr_boundary = rst_n && !core_stall && !core_sleeping;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wake_done <= 1'b0;
			program_counter <= 14'h0000;
		end else begin
			// Start-up treated as done one cycle after the wake request
			wake_done <= core_sleeping && (wake_done || wake_request);
			program_counter <= program_counter + {13'h0000, instr_boundary};
		end
	end
endmodule

// ===== verif/cpu_interrupt_sequencer_tb_top.sv
`timescale 1ns/10ps
`include "irq_seq_map.vh"
module cpu_interrupt_sequencer_tb_top;
	reg         clk = 1'b0;
	reg         rst_n = 1'b0;
	reg  [3:0]  reg_addr = 4'h0;
	reg  [7:0]  reg_wdata = 8'h00;
	reg         reg_wr = 1'b0;
	reg         reg_rd = 1'b0;
	reg  [7:0]  irq_event = 8'h00;
	reg  [2:0]  instr_q = 3'h0;
	reg         core_sleeping = 1'b0;
	reg  [7:0]  irq_level = 8'h00;
	reg         boot_reset_vector_fuse = 1'b0;
	reg         app_section_lock_bit = 1'b0;
	reg         reset_fetch = 1'b0;
	wire [7:0]  reg_rdata;
	wire [13:0] program_counter, vector_addr;
	wire [15:0] stack_pointer;
	wire        instr_boundary, wake_done, core_stall, push_strobe, pop_strobe;
	wire        vector_load, wake_request, global_irq_enable;
	integer     n_errors = 0;
	integer     tests_run = 0;
	integer     i;
	initial forever #2 clk = ~clk;
	cpu_interrupt_sequencer cpu_interrupt_sequencer_inst (
		.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.irq_event(irq_event), .irq_level(irq_level),
		.boot_reset_vector_fuse(boot_reset_vector_fuse),
		.app_section_lock_bit(app_section_lock_bit), .boot_section_lock_bit(1'b0),
		.instr_boundary(instr_boundary), .instr_sei(instr_q[2]), .instr_cli(instr_q[1]),
		.return_from_interrupt(instr_q[0]), .core_sleeping(core_sleeping),
		.wake_done(wake_done), .program_counter(program_counter), .reset_fetch(reset_fetch),
		.core_stall(core_stall), .push_strobe(push_strobe), .pop_strobe(pop_strobe),
		.vector_addr(vector_addr), .vector_load(vector_load),
		.wake_request(wake_request), .global_irq_enable(global_irq_enable),
		.stack_pointer(stack_pointer));
	core_model core_model_inst (.clk(clk), .rst_n(rst_n), .core_stall(core_stall),
		.core_sleeping(core_sleeping), .wake_request(wake_request),
		.instr_boundary(instr_boundary), .wake_done(wake_done),
		.program_counter(program_counter));
	task chk(input [15:0] seen, input [15:0] exp);
		begin
			tests_run = tests_run + 1;
			if (seen !== exp) begin
				n_errors = n_errors + 1;
				$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task wr(input [3:0] a, input [7:0] d);
		begin
			@(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
			@(posedge clk) reg_wr <= 1'b0;
		end
	endtask
	task rd(input [3:0] a, input [7:0] e);
		begin
			@(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
			@(posedge clk) reg_rd <= 1'b0;
			#1 chk({8'h00, reg_rdata}, {8'h00, e});
		end
	endtask
	// Instruction pulse: {set, clear, return}
	task ins(input [2:0] k);
		begin
			@(posedge clk) instr_q <= k;
			@(posedge clk) instr_q <= 3'h0;
		end
	endtask
	task fire(input [7:0] m);
		begin
			@(posedge clk) irq_event <= m;
			repeat (4) @(posedge clk);
			irq_event <= 8'h00;
		end
	endtask
	// Bounded wait, so a lost request shows as a mismatch, not a hang
	task wait_load(input [13:0] e);
		begin
			for (i = 0; i < 80 && vector_load !== 1'b1; i = i + 1) @(negedge clk);
			chk({15'h0000, vector_load}, 16'h0001);
			chk({2'b00, vector_addr}, {2'b00, e});
		end
	endtask
	task close_out;
		begin
			if (n_errors == 0 && tests_run > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	initial begin
		#20000;
		n_errors = n_errors + 1;
		close_out;
	end
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rd(`ADDR_SP_LO, 8'h5f);
		rd(`ADDR_SP_HI, 8'h08);
		rd(`ADDR_STATUS, 8'h00);
		wr(`ADDR_ENABLE, 8'h01);
		ins(3'h4);
		rd(`ADDR_STATUS, 8'h80);
		fire(8'h01);
		wait_load(14'h0002);
		chk({15'h0000, global_irq_enable}, 16'h0000);
		rd(`ADDR_FLAGS, 8'h00);
		rd(`ADDR_SP_LO, 8'h5d);
		ins(3'h1);
		repeat (4) @(posedge clk);
		#1 chk({15'h0000, global_irq_enable}, 16'h0001);
		rd(`ADDR_SP_LO, 8'h5f);
		ins(3'h2);
		fire(8'h0a);
		wr(`ADDR_ENABLE, 8'h0a);
		rd(`ADDR_FLAGS, 8'h0a);
		chk({15'h0000, core_stall}, 16'h0000);
		ins(3'h4);
		wait_load(14'h0004);
		ins(3'h1);
		wait_load(14'h0008);
		ins(3'h1);
		repeat (6) @(posedge clk);
		ins(3'h2);
		fire(8'h04);
		wr(`ADDR_FLAGS, 8'h00);
		rd(`ADDR_FLAGS, 8'h04);
		wr(`ADDR_FLAGS, 8'h04);
		rd(`ADDR_FLAGS, 8'h00);
		// Level source: a pulse while global enable is off is forgotten, a held level is taken
		wr(`ADDR_ENABLE, 8'h80);
		@(posedge clk) irq_level <= 8'h80;
		repeat (4) @(posedge clk);
		irq_level <= 8'h00;
		repeat (4) @(posedge clk);
		ins(3'h4);
		repeat (6) @(posedge clk);
		#1 chk({15'h0000, core_stall}, 16'h0000);
		rd(`ADDR_FLAGS, 8'h00);
		@(posedge clk) irq_level <= 8'h80;
		wait_load(14'h0010);
		@(posedge clk) irq_level <= 8'h00;
		ins(3'h1);
		repeat (6) @(posedge clk);
		wr(`ADDR_CONTROL, 8'h01);
		wr(`ADDR_ENABLE, 8'h01);
		@(posedge clk) app_section_lock_bit <= 1'b1;
		ins(3'h4);
		fire(8'h01);
		repeat (6) @(posedge clk);
		#1 chk({15'h0000, core_stall}, 16'h0000);
		rd(`ADDR_FLAGS, 8'h01);
		@(posedge clk) app_section_lock_bit <= 1'b0;
		wait_load(14'h3802);
		ins(3'h1);
		repeat (6) @(posedge clk);
		@(posedge clk) core_sleeping <= 1'b1;
		fire(8'h01);
		wait_load(14'h3802);
		@(posedge clk) core_sleeping <= 1'b0;
		// Reset fetch while global enable is still off after the last entry
		@(posedge clk) reset_fetch <= 1'b1;
		@(posedge clk) reset_fetch <= 1'b0;
		wait_load(14'h0000);
		@(posedge clk) {boot_reset_vector_fuse, reset_fetch} <= 2'b11;
		@(posedge clk) reset_fetch <= 1'b0;
		wait_load(14'h3800);
		close_out;
	end
endmodule
